// file: design/asr_pkg.sv
// package for the asynchronous serial receiver: register map, fields, timing
package asr_pkg;
   // register indices on the plain register port
   localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0; // receive_status_control
   localparam logic [1:0] ADDR_RECEIVE_DATA = 2'h1;   // receive_data_register, read pops
   localparam logic [1:0] ADDR_INTERRUPT_CTRL = 2'h2; // interrupt_control_reg
   localparam logic [1:0] ADDR_REQUEST_STATUS = 2'h3; // request flag and enable

   // receive_status_control field positions
   localparam int BIT_SERIAL_PORT_ENABLE = 7;
   localparam int BIT_NINE_BIT_SELECT = 6;
   localparam int BIT_CONT_RECEIVE = 4;
   localparam int BIT_ADDRESS_DETECT = 3;
   localparam int BIT_FRAME_ERROR = 2;
   localparam int BIT_OVERRUN_ERROR = 1;
   localparam int BIT_NINTH_BIT = 0;
   // interrupt_control_reg field positions
   localparam int BIT_GLOBAL_IE = 7;
   localparam int BIT_PERIPH_IE = 6;
   // request status register field positions
   localparam int BIT_PENDING = 0;
   localparam int BIT_RX_IE = 1;

   // timing: bit time at the system clock
   localparam int CLOCK_MHZ = 125;
   localparam int BAUD_RATE = 115200;
   localparam int BIT_CYCLES = (CLOCK_MHZ * 1000000) / BAUD_RATE;
   localparam logic [11:0] BIT_COUNT = 12'(BIT_CYCLES - 1);
   localparam logic [11:0] HALF_COUNT = 12'(BIT_CYCLES / 2 - 1);

   localparam int FIFO_DEPTH = 2;
   localparam logic [7:0] RESET_CONTROL = 8'h00;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } asr_state_t;

   // one receive FIFO entry
   typedef struct packed {
      logic frameErr;
      logic ninth;
      logic [7:0] data;
   } asr_entry_t;
endpackage : asr_pkg

// file: design/asr_receiver.sv
// receive path of an asynchronous serial port with a two-entry FIFO
//
// Contract
// [R1] pending flag high while enabled and FIFO holds an unread character; software cannot write it
// [R2] interrupt request only when pending, rx, peripheral and global enables all set
// [R3] pending flag follows FIFO occupancy regardless of enables
// [R4] each FIFO entry stores a framing-error bit, set when stop bit missing
// [R5] framing-error status read-only, shows oldest unread entry
// [R6] data read pops oldest; status then shows next character's values
// [R7] framing error never blocks later reception, needs no clearing
// [R8] port enable low resets receiver, clears framing error; continuous-receive low does not
// [R9] framing error alone raises no interrupt
// [R10] reads keep framing error high if all remaining entries have errors
// [R11] FIFO holds exactly two characters with error and ninth bit
// [R12] third complete character while FIFO full sets overrun
// [R13] during overrun stored characters stay readable, no new ones accepted
// [R14] overrun cleared only by continuous-receive low or port enable low
// [R15] nine-bit mode shifts nine bits; extra bit is entry's top bit
// [R16] software reads ninth bit before low data byte
// [R17] software reads framing error before data register
// [R18] address detection acts only in nine-bit mode
// [R19] address detection keeps only characters whose ninth bit is one
// [R20] software clears address detect on match, sets it at message end
// [R21] empty FIFO: pending low, data read changes nothing
`timescale 1ns/1ns
module asr_receiver
   import asr_pkg::*;
(
   input wire logic clock,           // system clock, 125 MHz
   input wire logic reset_n,         // asynchronous reset, active low
   input wire logic rxLine,          // serial line, idle high
   input wire logic [1:0] regAddr,   // register index
   input wire logic [7:0] regWdata,  // write data
   input wire logic regWrite,        // write strobe
   input wire logic regRead,         // read strobe
   output logic [7:0] regRdata,      // read data, one cycle after strobe
   output logic rxIrq                // receive interrupt request
);

   // control registers
   logic [7:0] control_ff, nxt_control;
   logic [1:0] intCtrl_ff, nxt_intCtrl;
   logic rxIe_ff, nxt_rxIe;
   logic portEn, contRx, nineSel, addrDet;

   // receiver state
   asr_state_t state_ff, nxt_state;
   logic [11:0] timer_ff, nxt_timer;
   logic [3:0] bitIdx_ff, nxt_bitIdx;
   logic [8:0] shift_ff, nxt_shift;
   logic lineS1_ff, lineS2_ff;

   // FIFO: flip-flop storage addressed by read index
   asr_entry_t fifo_ff [FIFO_DEPTH], nxt_fifo [FIFO_DEPTH];
   logic rdIdx_ff, nxt_rdIdx;
   logic [1:0] count_ff, nxt_count;
   logic overrun_ff, nxt_overrun;

   logic [7:0] rdata_ff, nxt_rdata;
   logic irq_ff, nxt_irq;

   logic charDone, stopOk, keepChar, popReq, pending;
   asr_entry_t newEntry, headEntry;

   assign portEn = control_ff[BIT_SERIAL_PORT_ENABLE];
   assign contRx = control_ff[BIT_CONT_RECEIVE];
   assign nineSel = control_ff[BIT_NINE_BIT_SELECT];
   assign addrDet = control_ff[BIT_ADDRESS_DETECT] & nineSel; // see [R18]
   assign headEntry = fifo_ff[rdIdx_ff];
   assign pending = portEn && (count_ff != 2'h0); // see [R1] see [R3] see [R21]

   // line synchroniser; the first stage feeds only the second
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lineS1_ff <= 1'b1;
         lineS2_ff <= 1'b1;
      end else begin
         lineS1_ff <= rxLine;
         lineS2_ff <= lineS1_ff;
      end
   end

   // control registers; the flags are not writable bits
   always_comb begin
      nxt_control = control_ff;
      nxt_intCtrl = intCtrl_ff;
      nxt_rxIe = rxIe_ff;
      if (regWrite) begin
         case (regAddr)
            ADDR_STATUS_CONTROL: nxt_control = regWdata & 8'hD8; // see [R1] see [R5]
            ADDR_INTERRUPT_CTRL: nxt_intCtrl = {regWdata[BIT_GLOBAL_IE], regWdata[BIT_PERIPH_IE]};
            ADDR_REQUEST_STATUS: nxt_rxIe = regWdata[BIT_RX_IE];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         control_ff <= RESET_CONTROL;
         intCtrl_ff <= 2'h0;
         rxIe_ff <= 1'b0;
      end else begin
         control_ff <= nxt_control;
         intCtrl_ff <= nxt_intCtrl;
         rxIe_ff <= nxt_rxIe;
      end
   end

   // bit-timing state machine; samples mid-bit, runs only while receiving
   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_ff;
      nxt_bitIdx = bitIdx_ff;
      nxt_shift = shift_ff;
      charDone = 1'b0;
      stopOk = 1'b0;
      if (!portEn || !contRx) begin
         nxt_state = RX_IDLE; // see [R8]
         nxt_timer = 12'h000;
      end else begin
         case (state_ff)
            RX_IDLE: begin
               if (!lineS2_ff) begin
                  nxt_state = RX_START;
                  nxt_timer = HALF_COUNT;
               end
            end
            RX_START: begin
               if (timer_ff != 12'h000) begin
                  nxt_timer = timer_ff - 12'h001;
               end else if (lineS2_ff) begin
                  nxt_state = RX_IDLE; // glitch, not a start bit
               end else begin
                  nxt_state = RX_DATA;
                  nxt_timer = BIT_COUNT;
                  nxt_bitIdx = 4'h0;
               end
            end
            RX_DATA: begin
               if (timer_ff != 12'h000) begin
                  nxt_timer = timer_ff - 12'h001;
               end else begin
                  // lsb first; nine-bit mode shifts one more bit in
                  nxt_shift = {lineS2_ff, shift_ff[8:1]}; // see [R15]
                  nxt_timer = BIT_COUNT;
                  nxt_bitIdx = bitIdx_ff + 4'h1;
                  if (bitIdx_ff == (nineSel ? 4'h8 : 4'h7)) begin
                     nxt_state = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (timer_ff != 12'h000) begin
                  nxt_timer = timer_ff - 12'h001;
               end else begin
                  charDone = 1'b1;
                  stopOk = lineS2_ff; // see [R4]
                  nxt_state = RX_IDLE; // see [R7]
               end
            end
            default: nxt_state = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= RX_IDLE;
         timer_ff <= 12'h000;
         bitIdx_ff <= 4'h0;
         shift_ff <= 9'h000;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         bitIdx_ff <= nxt_bitIdx;
         shift_ff <= nxt_shift;
      end
   end

   // assemble the finished character; eight-bit data sit in the top of the shifter
   always_comb begin
      newEntry.frameErr = !stopOk; // see [R4]
      newEntry.ninth = nineSel ? shift_ff[8] : 1'b0; // see [R15]
      newEntry.data = nineSel ? shift_ff[7:0] : shift_ff[8:1];
      keepChar = charDone && (!addrDet || newEntry.ninth); // see [R19]
   end

   // FIFO, overrun and read data; a pop on an empty FIFO changes nothing
   always_comb begin
      nxt_fifo = fifo_ff;
      nxt_rdIdx = rdIdx_ff;
      nxt_count = count_ff;
      nxt_overrun = overrun_ff;
      nxt_rdata = 8'h00;
      popReq = regRead && (regAddr == ADDR_RECEIVE_DATA) && (count_ff != 2'h0); // see [R6] see [R21]
      if (regRead) begin
         case (regAddr)
            ADDR_STATUS_CONTROL: nxt_rdata = (control_ff & 8'hD8)
                                 | {5'h00, headEntry.frameErr & (count_ff != 2'h0), overrun_ff,
                                    headEntry.ninth & (count_ff != 2'h0)}; // see [R5] see [R16] see [R17]
            ADDR_RECEIVE_DATA: nxt_rdata = (count_ff != 2'h0) ? headEntry.data : 8'h00;
            ADDR_INTERRUPT_CTRL: nxt_rdata = {intCtrl_ff, 6'h00};
            ADDR_REQUEST_STATUS: nxt_rdata = {6'h00, rxIe_ff, pending};
            default: nxt_rdata = 8'h00;
         endcase
      end
      if (popReq) begin
         nxt_rdIdx = !rdIdx_ff; // see [R6] see [R10]
      end
      if (keepChar && !overrun_ff) begin
         if (count_ff == 2'(FIFO_DEPTH) && !popReq) begin
            nxt_overrun = 1'b1; // see [R12] see [R13]
         end else begin
            nxt_fifo[rdIdx_ff ^ count_ff[0]] = newEntry; // see [R11]
         end
      end
      nxt_count = count_ff + {1'b0, keepChar && !overrun_ff && !nxt_overrun} - {1'b0, popReq};
      if (!contRx) begin
         nxt_overrun = 1'b0; // see [R14]
      end
      if (!portEn) begin
         // port disable resets the receiver and its status
         nxt_overrun = 1'b0; // see [R8] see [R14]
         nxt_count = 2'h0;
         nxt_rdIdx = 1'b0;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            nxt_fifo[i] = '0;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_ff[i] <= '0;
         end
         rdIdx_ff <= 1'b0;
         count_ff <= 2'h0;
         overrun_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         fifo_ff <= nxt_fifo;
         rdIdx_ff <= nxt_rdIdx;
         count_ff <= nxt_count;
         overrun_ff <= nxt_overrun;
         rdata_ff <= nxt_rdata;
      end
   end

   // interrupt request gated by three enables; errors never reach it
   always_comb begin
      nxt_irq = pending && rxIe_ff && intCtrl_ff[1] && intCtrl_ff[0]; // see [R2] see [R9]
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   assign regRdata = rdata_ff;
   assign rxIrq = irq_ff;

   // assertions
   irq_gating_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R2]
      rxIrq |-> $past(pending) && $past(rxIe_ff) && $past(intCtrl_ff) == 2'h3)
      else $error("interrupt without all enables");
   irq_follows_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R9]
      (pending && rxIe_ff && intCtrl_ff == 2'h3) |=> rxIrq)
      else $error("interrupt missing");
   pending_empty_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R21]
      (regRead && regAddr == ADDR_REQUEST_STATUS && count_ff == 2'h0) |=> !regRdata[BIT_PENDING])
      else $error("pending with empty fifo");
   fifo_depth_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R11]
      count_ff <= 2'h2)
      else $error("fifo over depth");
   overrun_set_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R12]
      (keepChar && count_ff == 2'h2 && !popReq && contRx && portEn) |=> overrun_ff)
      else $error("overrun not set");
   overrun_hold_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R14]
      (overrun_ff && contRx && portEn) |=> overrun_ff)
      else $error("overrun cleared wrongly");
   overrun_block_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R13]
      (overrun_ff && !popReq && portEn) |=> count_ff == $past(count_ff))
      else $error("fifo changed during overrun");
   pop_moves_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R6]
      popReq |=> rdIdx_ff != $past(rdIdx_ff) || !portEn)
      else $error("pop did not advance");
   empty_read_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R21]
      (regRead && regAddr == ADDR_RECEIVE_DATA && count_ff == 2'h0 && !keepChar && portEn)
      |=> count_ff == 2'h0 && rdIdx_ff == $past(rdIdx_ff))
      else $error("empty read changed fifo");
   addr_filter_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R19]
      (charDone && addrDet && !newEntry.ninth && !popReq && portEn) |=> count_ff == $past(count_ff))
      else $error("non-address character stored");
   disable_clear_a: assert property (@(posedge clock) disable iff (!reset_n) // see [R8]
      !portEn |=> count_ff == 2'h0 && !overrun_ff)
      else $error("port disable did not reset");
endmodule : asr_receiver

// file: dv/asr_line_partner.sv
// far-end transmitter model that drives the shared serial line
`timescale 1ns/1ns
module asr_line_partner
   import asr_pkg::*;
(
   input wire logic clock, // system clock, paces the bit time
   output logic rxLine     // serial line toward the receiver
);
   // line rests high between frames, as a pulled-up bus would
   initial begin
      rxLine = 1'b1;
   end

   // one bit cell, changed just after an edge so the receiver never races it
   task automatic putBit(input logic b);
      rxLine <= b;
      repeat (BIT_CYCLES) @(posedge clock);
   endtask : putBit

   // start, lsb-first data, stop (driven low on request), then one idle cell
   task automatic sendChar(input logic [8:0] val, input logic nine, input logic badStop);
      @(posedge clock);
      putBit(1'b0);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         putBit(val[i]);
      end
      putBit(!badStop);
      putBit(1'b1);
   endtask : sendChar
endmodule : asr_line_partner

// file: dv/tb.sv
// self-checking testbench for the serial receiver
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin errTotal++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb;
   import asr_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic rxLine;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata;
   logic rxIrq;
   int errTotal = 0;
   int samplesChecked = 0;

   always #4 clock = ~clock;

   asr_receiver dut_u (.clock(clock), .reset_n(reset_n), .rxLine(rxLine), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxIrq(rxIrq));
   asr_line_partner lineModel (.clock(clock), .rxLine(rxLine));

   // one-cycle write strobe
   task automatic writeReg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : writeReg

   // one-cycle read strobe; data is looked at only in the following cycle
   task automatic readChk(input logic [1:0] a, input logic [7:0] exp, input string nm);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      `CHK(nm, exp, regRdata)
   endtask : readChk

   task automatic completeRun;
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : completeRun

   // watchdog sized for six characters plus register traffic
   initial begin
      repeat (90000) @(posedge clock);
      errTotal++;
      completeRun();
   end

   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      // empty and disabled after reset
      readChk(ADDR_STATUS_CONTROL, 8'h00, "status");
      readChk(ADDR_RECEIVE_DATA, 8'h00, "data");
      readChk(ADDR_REQUEST_STATUS, 8'h00, "request");
      writeReg(ADDR_STATUS_CONTROL, 8'h90);
      writeReg(ADDR_INTERRUPT_CTRL, 8'hC0);
      writeReg(ADDR_REQUEST_STATUS, 8'h03); // pending bit written but must stay read-only
      readChk(ADDR_REQUEST_STATUS, 8'h02, "request");
      // good char, then one with a missing stop bit
      lineModel.sendChar(9'h0A5, 1'b0, 1'b0);
      lineModel.sendChar(9'h03C, 1'b0, 1'b1);
      readChk(ADDR_REQUEST_STATUS, 8'h03, "request");
      `CHK("rxIrq", 1'b1, rxIrq)
      // dropping the global enable gates the request but not the flag
      writeReg(ADDR_INTERRUPT_CTRL, 8'h40);
      repeat (2) @(posedge clock);
      #1;
      `CHK("rxIrq", 1'b0, rxIrq)
      readChk(ADDR_REQUEST_STATUS, 8'h03, "request");
      // address detect in eight-bit mode must stay inert, so the third char still overruns
      writeReg(ADDR_STATUS_CONTROL, 8'h98);
      lineModel.sendChar(9'h00F, 1'b0, 1'b0);
      readChk(ADDR_STATUS_CONTROL, 8'h9A, "status");
      readChk(ADDR_RECEIVE_DATA, 8'hA5, "data");
      readChk(ADDR_STATUS_CONTROL, 8'h9E, "status");
      // continuous receive off clears overrun, keeps frame error
      writeReg(ADDR_STATUS_CONTROL, 8'h80);
      readChk(ADDR_STATUS_CONTROL, 8'h84, "status");
      readChk(ADDR_RECEIVE_DATA, 8'h3C, "data");
      readChk(ADDR_STATUS_CONTROL, 8'h80, "status");
      readChk(ADDR_RECEIVE_DATA, 8'h00, "data");
      readChk(ADDR_REQUEST_STATUS, 8'h02, "request");
      // nine-bit with address detection: ninth-bit-zero char must vanish
      writeReg(ADDR_STATUS_CONTROL, 8'hD8);
      lineModel.sendChar(9'h055, 1'b1, 1'b0);
      lineModel.sendChar(9'h1AA, 1'b1, 1'b1);
      readChk(ADDR_STATUS_CONTROL, 8'hDD, "status");
      readChk(ADDR_REQUEST_STATUS, 8'h03, "request");
      readChk(ADDR_RECEIVE_DATA, 8'hAA, "data");
      // address matched: detection off, so a data char with ninth bit zero gets in
      writeReg(ADDR_STATUS_CONTROL, 8'hD0);
      lineModel.sendChar(9'h033, 1'b1, 1'b1);
      readChk(ADDR_STATUS_CONTROL, 8'hD4, "status");
      // message over: detection back on, then port disable resets receiver and frame error
      writeReg(ADDR_STATUS_CONTROL, 8'hD8);
      writeReg(ADDR_STATUS_CONTROL, 8'h58);
      readChk(ADDR_STATUS_CONTROL, 8'h58, "status");
      readChk(ADDR_REQUEST_STATUS, 8'h02, "request");
      readChk(ADDR_RECEIVE_DATA, 8'h00, "data");
      completeRun();
   end
endmodule : tb
